/* File: rtl/pms_pkg.sv */
// Purpose: shared constants for the power-management status outputs
// Assumes: single clock domain, 250 MHz
// Notes: register offsets are byte addresses on a plain strobe port
package pms_pkg;
    localparam logic [7:0] PMS_OFF_CTRL = 8'h00;
    localparam logic [7:0] PMS_OFF_STATE = 8'h04;
    localparam logic [7:0] PMS_OFF_DPA = 8'h08;
    localparam logic [7:0] PMS_OFF_IRQ_STAT = 8'h0c;
    localparam logic [7:0] PMS_OFF_IRQ_MASK = 8'h10;
    localparam int PMS_CTRL_ROOT_BIT = 0;
    localparam int PMS_CTRL_FLUSH_LSB = 4;
    localparam logic [1:0] PMS_FLUSH_RESET = 2'h0;
    localparam logic [3:0] PMS_MASK_RESET = 4'h0;
    localparam logic [3:0] PMS_DPA_RESET = 4'h0;
    localparam logic [3:0] PMS_STAT_RESET = 4'h0;
    localparam logic [31:0] PMS_RDATA_RESET = 32'h0;
    localparam int PMS_IRQ_DPA0 = 0;
    localparam int PMS_IRQ_DPA1 = 1;
    localparam int PMS_IRQ_RX_CHG = 2;
    localparam int PMS_IRQ_TX_CHG = 3;
    localparam int PMS_NUM_PF = 2;
    localparam logic [1:0] PMS_DPA_RSVD = 2'h0;
    typedef enum logic [1:0] {
        pms_not_in_standby,
        pms_standby_entry,
        pms_standby_idle,
        pms_standby_fast_train
    } pms_l0s_t;
    typedef enum logic [1:0] {
        pms_flush_off,
        pms_flush_msg_a,
        pms_flush_msg_b,
        pms_flush_wake
    } pms_flush_t;
endpackage : pms_pkg

/* File: rtl/pms_sync2.sv */
// Purpose: two-flop synchroniser for pin-level inputs
// Assumes: asynchronous active-low reset
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module pms_sync2 #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= i_d;
            q_reg <= meta_reg;
        end
    end
    assign o_q = q_reg;
endmodule : pms_sync2

/* File: rtl/pms_status.sv */
// Purpose: power-management status outputs toward user logic
// Assumes: link-side substates and config writes come from same-clock logic
// Notes: mode strap pin synchronised; registers on a plain strobe port
//
// Notes on behaviour
// RULE_01: drive 2-bit receive standby substate
// RULE_02: drive 2-bit transmit standby substate
// RULE_03: user ignores substates outside L0
// RULE_04: endpoint pulses per-function allocation change bit
// RULE_05: upper two bits reserved; root mode silent
// RULE_06: mirror 2-bit buffer flush/fill enable
`timescale 1ns/10ps
module pms_status (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_root_mode_pin,
    input wire logic [1:0] i_rx_state,
    input wire logic [1:0] i_tx_state,
    input wire logic [1:0] i_dpa_cfg_write,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rx_l0s_substate,
    output logic [1:0] o_tx_l0s_substate,
    output logic [3:0] o_dpa_substate_change,
    output logic [1:0] o_flush_enable,
    output logic o_irq
);
    // ----------------------------------------
    // mode strap
    // ----------------------------------------
    logic root_sync;
    pms_sync2 #(.W(1)) u_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_d(i_root_mode_pin),
        .o_q(root_sync)
    );

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;

    always_comb begin
        wr_ctrl = i_wr && hit(i_addr, pms_pkg::PMS_OFF_CTRL);
        wr_stat = i_wr && hit(i_addr, pms_pkg::PMS_OFF_IRQ_STAT);
        wr_mask = i_wr && hit(i_addr, pms_pkg::PMS_OFF_IRQ_MASK);
    end

    // ----------------------------------------
    // standby substates
    // ----------------------------------------
    pms_pkg::pms_l0s_t rx_reg;
    pms_pkg::pms_l0s_t rx_next;
    pms_pkg::pms_l0s_t tx_reg;
    pms_pkg::pms_l0s_t tx_next;
    logic rx_chg;
    logic tx_chg;

    always_comb begin
        // RULE_01 receive substate
        rx_next = pms_pkg::pms_l0s_t'(i_rx_state);
        // RULE_02 transmit substate
        tx_next = pms_pkg::pms_l0s_t'(i_tx_state);
        rx_chg = (rx_next != rx_reg);
        tx_chg = (tx_next != tx_reg);
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_reg <= pms_pkg::pms_not_in_standby;
            tx_reg <= pms_pkg::pms_not_in_standby;
        end else begin
            rx_reg <= rx_next;
            tx_reg <= tx_next;
        end
    end

    // ----------------------------------------
    // buffer flush/fill enable
    // ----------------------------------------
    pms_pkg::pms_flush_t flush_reg;
    pms_pkg::pms_flush_t flush_next;

    always_comb begin
        flush_next = flush_reg;
        // RULE_06 flush enable mirror
        if (wr_ctrl) begin
            flush_next = pms_pkg::pms_flush_t'(i_wdata[pms_pkg::PMS_CTRL_FLUSH_LSB +: 2]);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            flush_reg <= pms_pkg::pms_flush_off;
        end else begin
            flush_reg <= flush_next;
        end
    end

    // ----------------------------------------
    // power allocation change pulses
    // ----------------------------------------
    logic [pms_pkg::PMS_NUM_PF-1:0] dpa_pf;
    logic [3:0] dpa_reg;
    logic [3:0] dpa_next;

    // RULE_04 per-function change pulse
    // RULE_05 root mode silent
    for (genvar pf = 0; pf < pms_pkg::PMS_NUM_PF; pf++) begin : g_dpa
        assign dpa_pf[pf] = i_dpa_cfg_write[pf] && !root_sync;
    end

    always_comb begin
        // RULE_05 reserved bits zero
        dpa_next = {pms_pkg::PMS_DPA_RSVD, dpa_pf};
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dpa_reg <= pms_pkg::PMS_DPA_RESET;
        end else begin
            dpa_reg <= dpa_next;
        end
    end

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    logic [3:0] ev;
    logic [3:0] stat_reg;
    logic [3:0] stat_next;
    logic [3:0] mask_reg;
    logic [3:0] mask_next;

    always_comb begin
        ev = 4'h0;
        ev[pms_pkg::PMS_IRQ_DPA0] = dpa_next[0];
        ev[pms_pkg::PMS_IRQ_DPA1] = dpa_next[1];
        ev[pms_pkg::PMS_IRQ_RX_CHG] = rx_chg;
        ev[pms_pkg::PMS_IRQ_TX_CHG] = tx_chg;
        stat_next = stat_reg;
        if (wr_stat) begin
            stat_next = stat_reg & ~i_wdata[3:0];
        end
        // set wins over clear
        stat_next = stat_next | ev;
        mask_next = mask_reg;
        if (wr_mask) begin
            mask_next = i_wdata[3:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stat_reg <= pms_pkg::PMS_STAT_RESET;
            mask_reg <= pms_pkg::PMS_MASK_RESET;
        end else begin
            stat_reg <= stat_next;
            mask_reg <= mask_next;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // read data stands one cycle, zero otherwise
    always_comb begin
        rdata_next = 32'h0;
        if (i_rd) begin
            case (i_addr)
                pms_pkg::PMS_OFF_CTRL: begin
                    rdata_next = {26'h0, flush_reg, 3'h0, root_sync};
                end
                pms_pkg::PMS_OFF_STATE: begin
                    rdata_next = {28'h0, tx_reg, rx_reg};
                end
                pms_pkg::PMS_OFF_DPA: begin
                    rdata_next = {28'h0, dpa_reg};
                end
                pms_pkg::PMS_OFF_IRQ_STAT: begin
                    rdata_next = {28'h0, stat_reg};
                end
                pms_pkg::PMS_OFF_IRQ_MASK: begin
                    rdata_next = {28'h0, mask_reg};
                end
                default: begin
                    rdata_next = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_reg <= pms_pkg::PMS_RDATA_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_rx_l0s_substate = rx_reg;
    assign o_tx_l0s_substate = tx_reg;
    assign o_dpa_substate_change = dpa_reg;
    assign o_flush_enable = flush_reg;
    assign o_rdata = rdata_reg;
    // level output from registered status and mask only
    assign o_irq = |(stat_reg & ~mask_reg);
endmodule : pms_status

/* File: bench/pms_status_asserts.sv */
// Purpose: port checks on pms_status
// Assumes: one clock, async active-low reset
// Notes: pin low 3 edges covers the mode sync
`timescale 1ns/10ps
module pms_status_chk (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_root_mode_pin,
    input wire logic [1:0] i_rx_state,
    input wire logic [1:0] i_tx_state,
    input wire logic [1:0] i_dpa_cfg_write,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic [1:0] o_rx_l0s_substate,
    input wire logic [1:0] o_tx_l0s_substate,
    input wire logic [3:0] o_dpa_substate_change,
    input wire logic [1:0] o_flush_enable
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    wire ctl_wr = i_wr && i_addr == pms_pkg::PMS_OFF_CTRL;
    wire ep = !i_root_mode_pin;
    a_rx_follow: assert property (i_rst_b |=> o_rx_l0s_substate == $past(i_rx_state))
        else $error("rx substate wrong");
    a_tx_follow: assert property (i_rst_b |=> o_tx_l0s_substate == $past(i_tx_state))
        else $error("tx substate wrong");
    a_dpa_pulse: assert property (ep [*3] ##0 i_rst_b |=>
        o_dpa_substate_change[1:0] == $past(i_dpa_cfg_write))
        else $error("dpa pulse wrong");
    a_dpa_rsvd: assert property (o_dpa_substate_change[3:2] == 2'h0)
        else $error("dpa reserved set");
    a_root_quiet: assert property (i_root_mode_pin [*3] |=> o_dpa_substate_change == 4'h0)
        else $error("dpa in root mode");
    a_flush_wr: assert property (ctl_wr && i_rst_b |=> o_flush_enable == $past(i_wdata[5:4]))
        else $error("flush not written");
    a_flush_hold: assert property (!ctl_wr |=> $stable(o_flush_enable))
        else $error("flush changed");
    c_dpa: cover property (ep [*3] ##0 |i_dpa_cfg_write);
    c_root: cover property (i_root_mode_pin [*3] ##0 |i_dpa_cfg_write);
    c_flush: cover property (ctl_wr ##1 o_flush_enable == 2'h3);
endmodule : pms_status_chk
bind pms_status pms_status_chk u_chk (.i_clk, .i_rst_b, .i_root_mode_pin, .i_rx_state,
    .i_tx_state, .i_dpa_cfg_write, .i_addr, .i_wdata, .i_wr, .o_rx_l0s_substate,
    .o_tx_l0s_substate, .o_dpa_substate_change, .o_flush_enable);

/* File: bench/pms_user_model.sv */
// Purpose: user logic reading the standby substates
// Assumes: same clock as the block
// Notes: substates read as not in standby outside L0
`timescale 1ns/10ps
module pms_user_model (
    input wire logic i_in_l0,
    input wire logic [1:0] i_rx,
    input wire logic [1:0] i_tx,
    output logic [1:0] o_rx_q,
    output logic [1:0] o_tx_q
);
    assign o_rx_q = i_in_l0 ? i_rx : 2'h0;
    assign o_tx_q = i_in_l0 ? i_tx : 2'h0;
endmodule : pms_user_model

/* File: bench/test_pms_status.sv */
// Purpose: self-checking bench for pms_status
// Assumes: 250 MHz clock, inputs driven after rising edges
// Notes: timeout counts a mismatch
`timescale 1ns/10ps
module test_pms_status;
    logic i_clk = 1'h0, i_rst_b = 1'h0, i_root_mode_pin = 1'h0, i_wr = 1'h0, i_rd = 1'h0, o_irq;
    logic [1:0] i_rx_state = 2'h0, i_tx_state = 2'h0, i_dpa_cfg_write = 2'h0;
    logic [1:0] o_rx_l0s_substate, o_tx_l0s_substate, o_flush_enable, rx_q, tx_q;
    logic in_l0 = 1'h1;
    logic [7:0] i_addr = 8'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata, d;
    logic [3:0] o_dpa_substate_change;
    int bad_count = 0, samples_checked = 0, cyc = 0;
    pms_status uut (.i_clk, .i_rst_b, .i_root_mode_pin, .i_rx_state, .i_tx_state,
        .i_dpa_cfg_write, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_rx_l0s_substate,
        .o_tx_l0s_substate, .o_dpa_substate_change, .o_flush_enable, .o_irq);
    pms_user_model partner (.i_in_l0(in_l0), .i_rx(o_rx_l0s_substate),
        .i_tx(o_tx_l0s_substate), .o_rx_q(rx_q), .o_tx_q(tx_q));
    initial forever #2 i_clk = ~i_clk;
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_wr <= w;
        i_rd <= !w;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'h0;
        i_rd <= 1'h0;
        #1 d = o_rdata;
    endtask : bus
    task pulse(input logic [1:0] p);
        @(posedge i_clk);
        i_dpa_cfg_write <= p;
        @(posedge i_clk);
        i_dpa_cfg_write <= 2'h0;
        #1;
    endtask : pulse
    task t_sub;
        for (int v = 0; v < 4; v++) begin
            @(posedge i_clk);
            i_rx_state <= v[1:0];
            i_tx_state <= ~v[1:0];
            @(posedge i_clk);
            #1 chk("rx", o_rx_l0s_substate, v);
            chk("tx", o_tx_l0s_substate, 3 - v);
            chk("user tx", tx_q, 3 - v);
        end
        bus(1'h0, pms_pkg::PMS_OFF_STATE, 32'h0);
        chk("state reg", d, 32'h3);
        @(posedge i_clk);
        #1 chk("rdata idle", o_rdata, 32'h0);
        bus(1'h0, pms_pkg::PMS_OFF_IRQ_STAT, 32'h0);
        chk("change stat", d, 32'hc);
        chk("change irq", o_irq, 1'h1);
        chk("user rx", rx_q, 2'h3);
        @(posedge i_clk);
        in_l0 <= 1'h0;
        #1 chk("user rx off", rx_q, 2'h0);
        @(posedge i_clk);
        in_l0 <= 1'h1;
    endtask : t_sub
    task t_dpa;
        bus(1'h1, pms_pkg::PMS_OFF_IRQ_STAT, 32'hf);
        bus(1'h1, pms_pkg::PMS_OFF_IRQ_MASK, 32'h3);
        for (int p = 1; p < 3; p++) begin
            pulse(p[1:0]);
            chk("dpa", o_dpa_substate_change, p);
            chk("irq", o_irq, 1'h0);
        end
        @(posedge i_clk);
        #1 chk("dpa end", o_dpa_substate_change, 4'h0);
        @(posedge i_clk);
        i_dpa_cfg_write <= 2'h2;
        @(posedge i_clk);
        i_dpa_cfg_write <= 2'h0;
        i_rd <= 1'h1;
        i_addr <= pms_pkg::PMS_OFF_DPA;
        @(posedge i_clk);
        i_rd <= 1'h0;
        #1 chk("dpa reg", o_rdata, 32'h2);
        bus(1'h0, pms_pkg::PMS_OFF_IRQ_STAT, 32'h0);
        chk("stat", d, 32'h3);
        bus(1'h1, pms_pkg::PMS_OFF_IRQ_MASK, 32'h0);
        chk("irq", o_irq, 1'h1);
        bus(1'h1, pms_pkg::PMS_OFF_IRQ_STAT, 32'h3);
        chk("irq", o_irq, 1'h0);
        @(posedge i_clk);
        i_dpa_cfg_write <= 2'h1;
        i_wr <= 1'h1;
        i_addr <= pms_pkg::PMS_OFF_IRQ_STAT;
        i_wdata <= 32'h1;
        @(posedge i_clk);
        i_dpa_cfg_write <= 2'h0;
        i_wr <= 1'h0;
        bus(1'h0, pms_pkg::PMS_OFF_IRQ_STAT, 32'h0);
        chk("set wins", d, 32'h1);
        bus(1'h1, pms_pkg::PMS_OFF_IRQ_STAT, 32'h1);
        chk("irq clear", o_irq, 1'h0);
    endtask : t_dpa
    task t_flush;
        for (int v = 0; v < 4; v++) begin
            bus(1'h1, pms_pkg::PMS_OFF_CTRL, v << pms_pkg::PMS_CTRL_FLUSH_LSB);
            chk("flush", o_flush_enable, v);
        end
        bus(1'h0, pms_pkg::PMS_OFF_CTRL, 32'h0);
        chk("ctrl reg", d, 32'h30);
        bus(1'h0, 8'h40, 32'h0);
        chk("unmapped", d, 32'h0);
    endtask : t_flush
    task t_reset;
        @(posedge i_clk);
        i_rst_b <= 1'h0;
        #1 chk("flush rst", o_flush_enable, 2'h0);
        chk("rx rst", o_rx_l0s_substate, 2'h0);
        chk("dpa rst", o_dpa_substate_change, 4'h0);
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'h1;
        @(posedge i_clk);
        #1 chk("rx rel", o_rx_l0s_substate, 2'h3);
        chk("flush rel", o_flush_enable, 2'h0);
    endtask : t_reset
    task t_root;
        bus(1'h1, pms_pkg::PMS_OFF_IRQ_STAT, 32'hf);
        @(posedge i_clk);
        i_root_mode_pin <= 1'h1;
        repeat (3) @(posedge i_clk);
        pulse(2'h3);
        chk("dpa root", o_dpa_substate_change, 4'h0);
        bus(1'h0, pms_pkg::PMS_OFF_IRQ_STAT, 32'h0);
        chk("stat root", d, 32'h0);
        bus(1'h0, pms_pkg::PMS_OFF_CTRL, 32'h0);
        chk("ctrl root", d, 32'h1);
    endtask : t_root
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'h1;
        t_sub;
        t_dpa;
        t_flush;
        t_reset;
        t_root;
        give_verdict;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            give_verdict;
        end
    end
endmodule : test_pms_status
